/* include/vic_defs.vh */
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH

// Register indices; byte address is four times the index
`define VIC_IDX_EXT_FLAGS 8'hA0
`define VIC_IDX_EDGE_SEL_A 8'hA4
`define VIC_IDX_EDGE_SEL_B 8'hA5
`define VIC_IDX_EN_A 8'hA8
`define VIC_IDX_EN_B 8'hA9
`define VIC_IDX_EN_C 8'hAA
`define VIC_IDX_EN_D 8'hAB
`define VIC_IDX_LVL_LOW 8'hB8
`define VIC_IDX_LVL_HIGH 8'hF8

// Reset values
`define VIC_RST_BYTE 8'h00
`define VIC_RST_SIX 6'h00
`define VIC_RST_EDGE_B 4'h0

// Field positions
`define VIC_GATE_BIT 7

// Edge select field codes
`define VIC_EDGE_NONE 2'h0
`define VIC_EDGE_RISE 2'h1
`define VIC_EDGE_FALL 2'h2
`define VIC_EDGE_BOTH 2'h3

// Vector layout
`define VIC_VEC_RESET 16'h0000
`define VIC_VEC_BASE 16'h0003
`define VIC_VEC_SHIFT 3

// Source counts
`define VIC_NUM_SRC 24
`define VIC_NUM_EXT 6
`define VIC_NUM_GRP 6

`endif

/* hdl/vectored_interrupt_controller.v */
// What this block does
// - Twenty four numbered sources: six external edges, peripherals on their own numbers.
// - Served source n vectors by long call to 0003H plus eight times n.
// - Hardware reset is non-maskable, vector 0000H, untouched by software bits.
// - Global gate bit 7 of first enable register blocks all maskable requests.
// - Global gate cleared on service entry, set again on return from interrupt.
// - Source n enabled by bit n mod 6 of enable register n div 6.
// - Six groups of four sources; group g holds g, g+6, g+12, g+18.
// - Group level high bit from high priority register, low bit from low one.
// - Level 3 highest, level 0 lowest; priority registers reset to zero.
// - Simultaneous requests of different level: the higher level is served first.
// - Within one level the lowest numbered source wins.
// - Running service preempted only by a strictly higher level request.
// - Request flag set on arrival, held until accepted, then cleared automatically.
// - Requests sampled only in last instruction cycle; core then does a long call.
// - Vector low byte settled on detection; core acknowledges in next command's first cycle.
// - Service entry within 3 to 9 machine cycles of instruction end.
// - Return from interrupt restores context and hands back priority control.
// - Any enabled pending request raises wake, whatever its level.
// - Writes to enable, priority or power control registers hold off new requests.
// - Two-bit edge select per external line; all fields reset to no edge.
// - Edge code 00 none, 01 rising, 10 falling, 11 either edge.
// - External flag set on selected edge, cleared on service entry or by writing 0.
// - Writing 1 to an external flag has no effect; acknowledge clears it.
//
// Local design decision: register access over Wishbone.
`include "vic_defs.vh"

module vectored_interrupt_controller #(
  parameter NUM_SRC = 24,
  parameter NUM_EXT = 6,
  parameter NUM_GRP = 6
) (
  // Clock and reset
  input wire CLOCK_I,
  input wire RSTN_I,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [9:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Request sources
  input wire [NUM_EXT-1:0] EXT_LINE_I,
  input wire [NUM_SRC-NUM_EXT-1:0] PERIPH_REQ_I,
  // CPU core handshake
  input wire INSTR_LAST_I,
  input wire INT_ACK_I,
  input wire RETI_I,
  input wire POWER_CTRL_WR_I,
  output reg INT_REQ_O,
  output reg [15:0] VEC_ADDR_O,
  output reg [7:0] VECTOR_LOW_BYTE_O,
  output reg [NUM_SRC-1:0] SRC_ACK_O,
  // Power-down release
  output reg WAKE_O
);

  // Register file
  // Enable and level registers keep only their six implemented bits
  reg global_request_gate;
  reg [5:0] source_enable_a;
  reg [5:0] source_enable_b;
  reg [5:0] source_enable_c;
  reg [5:0] source_enable_d;
  reg [5:0] group_level_low;
  reg [5:0] group_level_high;
  reg [7:0] edge_sel_a;
  reg [3:0] edge_sel_b;

  // Pending flags; low six are the external event flags
  // Upper eighteen are peripheral requests, cleared only by accept
  reg [NUM_SRC-1:0] pend;

  // Service state
  // One in-service bit per level; the highest set bit rules
  reg [3:0] in_service;
  reg [4:0] win_src;
  reg [1:0] win_lvl;
  reg hold;

  // Synchroniser and edge state per external line
  // Third stage remembers the last level for edge detection
  reg [NUM_EXT-1:0] sync1;
  reg [NUM_EXT-1:0] sync2;
  reg [NUM_EXT-1:0] sync3;
  wire [NUM_EXT-1:0] edge_hit;

  // Bus decode
  // A write lands on the edge that samples ack high
  wire bus_req = WB_CYC_I & WB_STB_I;
  wire wr_fire = bus_req & WB_WE_I & WB_ACK_O & WB_SEL_I[0];
  wire [7:0] reg_idx = WB_ADR_I[9:2];
  wire [7:0] wdat = WB_DAT_I[7:0];
  wire wr_flags = wr_fire & (reg_idx == `VIC_IDX_EXT_FLAGS);
  wire wr_en_a = wr_fire & (reg_idx == `VIC_IDX_EN_A);
  wire wr_ctrl = wr_fire & ((reg_idx == `VIC_IDX_EN_A) | (reg_idx == `VIC_IDX_EN_B) |
                            (reg_idx == `VIC_IDX_EN_C) | (reg_idx == `VIC_IDX_EN_D) |
                            (reg_idx == `VIC_IDX_LVL_LOW) | (reg_idx == `VIC_IDX_LVL_HIGH));

  // Core handshake events
  // Accept needs an open request; a stray acknowledge does nothing
  wire accept = INT_ACK_I & INT_REQ_O;
  wire [NUM_SRC-1:0] en_vec;
  wire [2*NUM_SRC-1:0] src_lvl;

  // Per-source enable bit and group level
  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s = s + 1) begin : g_src
      // Enable register n div 6, bit n mod 6
      if (s < 6) begin : g_ea
        assign en_vec[s] = source_enable_a[s % 6];
      end else if (s < 12) begin : g_eb
        assign en_vec[s] = source_enable_b[s % 6];
      end else if (s < 18) begin : g_ec
        assign en_vec[s] = source_enable_c[s % 6];
      end else begin : g_ed
        assign en_vec[s] = source_enable_d[s % 6];
      end
      // Level of source n is that of group n mod 6
      assign src_lvl[2*s+1:2*s] = {group_level_high[s % NUM_GRP], group_level_low[s % NUM_GRP]};
    end
  endgenerate

  // Edge detection on synchronised lines
  // A line with no edge selected never sets its flag
  genvar k;
  generate
    for (k = 0; k < NUM_EXT; k = k + 1) begin : g_ext
      wire [1:0] sel;
      wire rise;
      wire fall;
      if (k < 4) begin : g_a
        assign sel = edge_sel_a[2*k+1:2*k];
      end else begin : g_b
        assign sel = edge_sel_b[2*(k-4)+1:2*(k-4)];
      end
      assign rise = sync2[k] & ~sync3[k];
      assign fall = ~sync2[k] & sync3[k];
      // Polarity decode
      // Code 00 falls through to no edge
      assign edge_hit[k] = (sel == `VIC_EDGE_RISE) ? rise :
                           (sel == `VIC_EDGE_FALL) ? fall :
                           (sel == `VIC_EDGE_BOTH) ? (rise | fall) : 1'b0;
    end
  endgenerate

  // Two-stage synchroniser plus history stage
  // Only the second and history stages feed the detector; the first may be metastable
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1 <= {NUM_EXT{1'b0}};
      sync2 <= {NUM_EXT{1'b0}};
      sync3 <= {NUM_EXT{1'b0}};
    end else begin
      sync1 <= EXT_LINE_I;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Highest level now in service
  // Bit 0 alone still counts as level 0 in service
  reg svc_any;
  reg [1:0] svc_lvl;
  always @* begin
    svc_any = |in_service;
    svc_lvl = 2'h0;
    if (in_service[3]) begin
      svc_lvl = 2'h3;
    end else if (in_service[2]) begin
      svc_lvl = 2'h2;
    end else if (in_service[1]) begin
      svc_lvl = 2'h1;
    end
  end

  // Winner search: highest level, then lowest number
  // Scan runs downwards so the lowest number wins a tie
  // Candidates not above the running level are skipped
  reg [NUM_SRC-1:0] cand;
  reg found;
  reg [4:0] best_src;
  reg [1:0] best_lvl;
  reg [1:0] lvl_n;
  integer i;
  always @* begin
    cand = pend & en_vec & {NUM_SRC{global_request_gate}};
    found = 1'b0;
    best_src = 5'h00;
    best_lvl = 2'h0;
    lvl_n = 2'h0;
    for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
      lvl_n = src_lvl[2*i +: 2];
      if (cand[i] && (!svc_any || lvl_n > svc_lvl)) begin
        if (!found || lvl_n >= best_lvl) begin
          found = 1'b1;
          best_src = i[4:0];
          best_lvl = lvl_n;
        end
      end
    end
  end

  // Sample point: last instruction cycle, no open request, no hold-off
  wire sample = INSTR_LAST_I & found & ~INT_REQ_O & ~hold & ~wr_ctrl & ~POWER_CTRL_WR_I;
  wire [15:0] next_vec = `VIC_VEC_BASE + {8'h00, best_src, 3'b000};

  // Wishbone ack and read data
  // Unmapped indices read zero and are still acknowledged
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req & ~WB_ACK_O;
      WB_DAT_O <= 32'h0000_0000;
      if (bus_req & ~WB_ACK_O & ~WB_WE_I) begin
        case (reg_idx)
          `VIC_IDX_EXT_FLAGS: WB_DAT_O[5:0] <= pend[5:0];
          `VIC_IDX_EDGE_SEL_A: WB_DAT_O[7:0] <= edge_sel_a;
          `VIC_IDX_EDGE_SEL_B: WB_DAT_O[3:0] <= edge_sel_b;
          `VIC_IDX_EN_A: WB_DAT_O[7:0] <= {global_request_gate, 1'b0, source_enable_a};
          `VIC_IDX_EN_B: WB_DAT_O[5:0] <= source_enable_b;
          `VIC_IDX_EN_C: WB_DAT_O[5:0] <= source_enable_c;
          `VIC_IDX_EN_D: WB_DAT_O[5:0] <= source_enable_d;
          `VIC_IDX_LVL_LOW: WB_DAT_O[5:0] <= group_level_low;
          `VIC_IDX_LVL_HIGH: WB_DAT_O[5:0] <= group_level_high;
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers written by software
  // Only lane 0 carries data; other lanes are ignored
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      source_enable_a <= `VIC_RST_SIX;
      source_enable_b <= `VIC_RST_SIX;
      source_enable_c <= `VIC_RST_SIX;
      source_enable_d <= `VIC_RST_SIX;
      group_level_low <= `VIC_RST_SIX;
      group_level_high <= `VIC_RST_SIX;
      edge_sel_a <= `VIC_RST_BYTE;
      edge_sel_b <= `VIC_RST_EDGE_B;
    end else if (wr_fire) begin
      case (reg_idx)
        `VIC_IDX_EDGE_SEL_A: edge_sel_a <= wdat;
        `VIC_IDX_EDGE_SEL_B: edge_sel_b <= wdat[3:0];
        `VIC_IDX_EN_A: source_enable_a <= wdat[5:0];
        `VIC_IDX_EN_B: source_enable_b <= wdat[5:0];
        `VIC_IDX_EN_C: source_enable_c <= wdat[5:0];
        `VIC_IDX_EN_D: source_enable_d <= wdat[5:0];
        `VIC_IDX_LVL_LOW: group_level_low <= wdat[5:0];
        `VIC_IDX_LVL_HIGH: group_level_high <= wdat[5:0];
        default: edge_sel_b <= edge_sel_b;
      endcase
    end
  end

  // Global gate: entry clears, return sets, entry beats software
  // Nesting needs software to set the gate again inside a routine
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      global_request_gate <= 1'b0;
    end else if (accept) begin
      global_request_gate <= 1'b0;
    end else if (RETI_I) begin
      global_request_gate <= 1'b1;
    end else if (wr_en_a) begin
      global_request_gate <= wdat[`VIC_GATE_BIT];
    end
  end

  // Pending flags; a new arrival wins over any clear
  // Software clears only external flags; writing 1 leaves them
  reg [NUM_SRC-1:0] next_pend;
  reg [NUM_SRC-1:0] arrive;
  always @* begin
    arrive = {PERIPH_REQ_I, edge_hit};
    next_pend = pend;
    if (accept) begin
      next_pend[win_src] = 1'b0;
    end
    if (wr_flags) begin
      next_pend[5:0] = next_pend[5:0] & wdat[5:0];
    end
    next_pend = next_pend | arrive;
  end

  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pend <= {NUM_SRC{1'b0}};
    end else begin
      pend <= next_pend;
    end
  end

  // Hold-off after control writes
  // A request raised during a mask change could use stale enables
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hold <= 1'b0;
    end else begin
      hold <= wr_ctrl | POWER_CTRL_WR_I;
    end
  end

  // Request to core, vector and acknowledge pulses
  // Vector and winner stay frozen while the request waits
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      INT_REQ_O <= 1'b0;
      VEC_ADDR_O <= `VIC_VEC_RESET;
      VECTOR_LOW_BYTE_O <= 8'h00;
      SRC_ACK_O <= {NUM_SRC{1'b0}};
      win_src <= 5'h00;
      win_lvl <= 2'h0;
    end else begin
      SRC_ACK_O <= {NUM_SRC{1'b0}};
      if (accept) begin
        INT_REQ_O <= 1'b0;
        SRC_ACK_O[win_src] <= 1'b1;
      end else if (sample) begin
        INT_REQ_O <= 1'b1;
        VEC_ADDR_O <= next_vec;
        VECTOR_LOW_BYTE_O <= next_vec[7:0];
        win_src <= best_src;
        win_lvl <= best_lvl;
      end
    end
  end

  // Levels in service; return releases the topmost one
  // Return and accept in one cycle: release first, then mark
  reg [3:0] next_svc;
  always @* begin
    next_svc = in_service;
    if (RETI_I) begin
      if (in_service[3]) begin
        next_svc[3] = 1'b0;
      end else if (in_service[2]) begin
        next_svc[2] = 1'b0;
      end else if (in_service[1]) begin
        next_svc[1] = 1'b0;
      end else begin
        next_svc[0] = 1'b0;
      end
    end
    if (accept) begin
      next_svc[win_lvl] = 1'b1;
    end
  end

  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      in_service <= 4'h0;
    end else begin
      in_service <= next_svc;
    end
  end

  // Wake from power-down on any enabled pending request
  // Gate ignored so a masked core still leaves power-down
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      WAKE_O <= 1'b0;
    end else begin
      WAKE_O <= |(pend & en_vec);
    end
  end

endmodule

/* dv/vic_chk.sv */
module vic_chk #(
  parameter NUM_SRC = 24
) (
  // Clock and reset
  input wire CLOCK_I,
  input wire RSTN_I,
  // Core handshake
  input wire INSTR_LAST_I,
  input wire INT_ACK_I,
  input wire POWER_CTRL_WR_I,
  input wire INT_REQ_O,
  input wire [15:0] VEC_ADDR_O,
  input wire [7:0] VECTOR_LOW_BYTE_O,
  input wire [NUM_SRC-1:0] SRC_ACK_O,
  input wire WAKE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  // Vector and request checks
  chk_reset_vec: assert property (
    $rose(RSTN_I) |-> VEC_ADDR_O == 16'h0000 && !INT_REQ_O) else $error("vector not cleared by reset");
  chk_vec_form: assert property (
    INT_REQ_O |-> VEC_ADDR_O[2:0] == 3'h3 && VEC_ADDR_O <= 16'h00BB) else $error("bad vector");
  chk_low_byte: assert property (
    INT_REQ_O |-> VECTOR_LOW_BYTE_O == VEC_ADDR_O[7:0]) else $error("low byte differs");
  chk_req_hold: assert property (
    INT_REQ_O && !INT_ACK_I |=> INT_REQ_O && $stable(VEC_ADDR_O)) else $error("request not held");
  chk_ack_clear: assert property (
    INT_REQ_O && INT_ACK_I |=> !INT_REQ_O && SRC_ACK_O == NUM_SRC'(1) << (($past(VEC_ADDR_O) - 3) >> 3))
    else $error("accept pulse wrong");
  chk_sample_point: assert property (
    $rose(INT_REQ_O) |-> $past(INSTR_LAST_I)) else $error("request off sample point");
  chk_write_holdoff: assert property (
    POWER_CTRL_WR_I |=> (!$rose(INT_REQ_O)) [*2]) else $error("request during write");
  chk_ack_cause: assert property (
    SRC_ACK_O != 0 |-> $past(INT_REQ_O && INT_ACK_I) && $onehot(SRC_ACK_O)) else $error("stray accept");
  // Main scenarios
  cover property ($rose(INT_REQ_O));
  cover property (INT_REQ_O && INT_ACK_I);
  cover property ($rose(WAKE_O));
endmodule
bind vectored_interrupt_controller vic_chk #(.NUM_SRC(NUM_SRC)) vic_chk_inst (.CLOCK_I, .RSTN_I,
  .INSTR_LAST_I, .INT_ACK_I, .POWER_CTRL_WR_I, .INT_REQ_O, .VEC_ADDR_O, .VECTOR_LOW_BYTE_O, .SRC_ACK_O, .WAKE_O);

/* dv/vic_core_model.sv */
module vic_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Handshake
  input wire logic req_i,
  input wire logic [3:0] wait_i,
  output logic last_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase;
  logic [3:0] wait_cnt;
  // Three-cycle instructions; ack after a chosen stall, in a first cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase <= 2'h0;
      wait_cnt <= 4'h0;
      ack_o <= 1'b0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      ack_o <= req_i && !ack_o && wait_cnt >= wait_i && phase == 2'h2;
      wait_cnt <= (req_i && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
  assign last_o = (phase == 2'h2);
endmodule

/* dv/vectored_interrupt_controller_tb_top.sv */
module vectored_interrupt_controller_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rstn = 0, cyc = 0, stb = 0, we = 0, reti = 0, pwr = 0;
  logic [9:0] adr = 0;
  logic [31:0] wdat = 0;
  logic [5:0] ext = 0;
  logic [17:0] preq = 0;
  logic [3:0] ack_wait = 0;
  logic [7:0] rd, lo, hi;
  logic [7:0] idx_t [10] = '{8'hA0, 8'hA4, 8'hA5, 8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hB8, 8'hF8, 8'h50};
  logic [7:0] msk_t [10] = '{8'h00, 8'hFF, 8'h0F, 8'hBF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h00};
  wire ack, req, last, iack, wake;
  wire [31:0] rdat;
  wire [15:0] vec;
  wire [7:0] vlow;
  wire [23:0] sack;
  int seed = 47, err_total = 0, check_count = 0, lvl[6], pend[$], best, n, wv;
  // System clock
  always #12.5 clock = ~clock;
  vectored_interrupt_controller vectored_interrupt_controller_inst (
    .CLOCK_I(clock), .RSTN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .EXT_LINE_I(ext), .PERIPH_REQ_I(preq),
    .INSTR_LAST_I(last), .INT_ACK_I(iack), .RETI_I(reti), .POWER_CTRL_WR_I(pwr), .INT_REQ_O(req),
    .VEC_ADDR_O(vec), .VECTOR_LOW_BYTE_O(vlow), .SRC_ACK_O(sack), .WAKE_O(wake));
  vic_core_model vic_core_model_inst (.clk_i(clock), .rstn_i(rstn), .req_i(req), .wait_i(ack_wait),
    .last_o(last), .ack_o(iack));
  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic single bus cycle, idle cycle after
  task automatic bus(input logic w, input logic [7:0] idx, d, output logic [7:0] q);
    int k;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    q = rdat[7:0];
    cyc <= 0;
    stb <= 0;
    @(posedge clock);
  endtask
  // Wait for request (0) or accept pulse (1)
  task automatic wait_sig(input int sel);
    for (int k = 0; k < 200; k++) begin
      @(posedge clock);
      if (sel == 0 ? req === 1'b1 : sack !== 0) return;
    end
    err_total++;
    tally_and_finish();
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    // Reset values, masks, unmapped place
    foreach (idx_t[i]) begin
      bus(0, idx_t[i], 0, rd);
      check(rd, 0);
      wv = $random(seed);
      bus(1, idx_t[i], wv[7:0], rd);
      bus(0, idx_t[i], 0, rd);
      check(rd, wv[7:0] & msk_t[i]);
      bus(1, idx_t[i], 0, rd);
    end
    // Every edge code; flags cleared by 0, kept on 1
    for (int c = 0; c < 4; c++) begin
      bus(1, 8'hA4, {4{c[1:0]}}, rd);
      bus(1, 8'hA5, {2{c[1:0]}}, rd);
      ext <= 6'h3F;
      repeat (5) @(posedge clock);
      bus(0, 8'hA0, 0, rd);
      check(rd, c[0] ? 8'h3F : 8'h00);
      bus(1, 8'hA0, 8'h00, rd);
      ext <= 6'h00;
      repeat (5) @(posedge clock);
      bus(1, 8'hA0, 8'hFF, rd);
      bus(0, 8'hA0, 0, rd);
      check(rd, c[1] ? 8'h3F : 8'h00);
      bus(1, 8'hA0, 8'h00, rd);
      bus(0, 8'hA0, 0, rd);
      check(rd, 8'h00);
    end
    // Random levels and simultaneous peripheral requests
    repeat (3) begin
      lo = 8'h00;
      hi = 8'h00;
      for (int g = 0; g < 6; g++) begin
        lvl[g] = $random(seed) & 3;
        lo[g] = lvl[g][0];
        hi[g] = lvl[g][1];
      end
      bus(1, 8'hB8, lo, rd);
      bus(1, 8'hF8, hi, rd);
      for (int r = 9; r < 12; r++) bus(1, r[7:0] + 8'hA0, 8'h3F, rd);
      wv = $random(seed) | 1;
      preq <= wv[17:0];
      @(posedge clock);
      preq <= 0;
      for (int j = 0; j < 18; j++) if (wv[j]) pend.push_back(j + 6);
      repeat (10) @(posedge clock);
      check(req, 0);
      check(wake, 1);
      pwr <= 1;
      bus(1, 8'hA8, 8'h80, rd);
      repeat (4) begin
        @(posedge clock);
        check(req, 0);
      end
      pwr <= 0;
      while (pend.size() > 0) begin
        best = 0;
        foreach (pend[j]) if (lvl[pend[j] % 6] * 32 - pend[j] > lvl[pend[best] % 6] * 32 - pend[best]) best = j;
        n = pend[best];
        pend.delete(best);
        ack_wait <= $random(seed) & 7;
        wait_sig(0);
        check(vec, 16'h0003 + 8 * n);
        check(vlow, (8'h03 + 8 * n) & 8'hFF);
        wait_sig(1);
        check(sack, 24'h00_0001 << n);
        bus(0, 8'hA8, 0, rd);
        check(rd, 8'h00);
        reti <= 1;
        @(posedge clock);
        reti <= 0;
      end
      repeat (3) @(posedge clock);
      check(wake, 0);
      bus(1, 8'hA8, 8'h00, rd);
    end
    // External line request served; acknowledge clears its flag
    ext <= 6'h01;
    bus(1, 8'hA8, 8'h81, rd);
    wait_sig(0);
    check(vec, 16'h0003);
    check(vlow, 8'h03);
    wait_sig(1);
    check(sack, 24'h00_0001);
    bus(0, 8'hA0, 0, rd);
    check(rd, 8'h00);
    // Falling edge sets the flag again; gate stays shut, wake rises
    ext <= 6'h00;
    repeat (5) @(posedge clock);
    check(req, 0);
    check(wake, 1);
    // Second reset in mid-run returns outputs and registers to zero
    rstn <= 0;
    repeat (3) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    check(req, 0);
    check(vec, 16'h0000);
    check(wake, 0);
    check(sack, 24'h00_0000);
    foreach (idx_t[i]) begin
      bus(0, idx_t[i], 0, rd);
      check(rd, 0);
    end
    tally_and_finish();
  end
endmodule
